// [design/evr_pkg.sv]
// Shared constants for the event router and its controller
package evr_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CH = 12;
  localparam int NUM_GEN_DEF = 74;
  localparam int NUM_USERS_DEF = 29;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CH_IDX_W = 4;
  localparam int USR_IDX_W = 5;
  localparam int CH_SEL_W = 5;
  localparam int GENERATOR_SELECT_W = 7;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CHANNEL = 8'h04;
  localparam logic [7:0] OFF_USER = 8'h08;
  localparam logic [7:0] OFF_CHSTATE = 8'h0C;
  localparam logic [7:0] OFF_INTEN_CLR = 8'h10;
  localparam logic [7:0] OFF_INTEN_SET = 8'h14;
  localparam logic [7:0] OFF_IRQ_FLAG_REG = 8'h18;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int B_SRST = 0;
  localparam int B_CLKREQ = 4;
  localparam int B_DBGSTOP = 6;
  localparam int B_CH_IDX = 0;
  localparam int B_SOFT_EVENT_BIT = 8;
  localparam int B_GENERATOR_SELECT = 16;
  localparam int B_EDGE = 26;
  localparam int B_PATH = 24;
  localparam int B_USR_IDX = 0;
  localparam int B_USR_CH = 8;
  localparam int B_HI = 16;
  // ****************************************
  // Access sizes and encodings
  // ****************************************
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} evr_size_t;
  localparam logic [1:0] PATH_SYNC = 2'h0;
  localparam logic [1:0] PATH_RESYNC = 2'h1;
  localparam logic [1:0] PATH_ASYNC = 2'h2;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // ****************************************
  // Controller register indices
  // ****************************************
  localparam logic [2:0] CR_TARGET = 3'h0;
  localparam logic [2:0] CR_WDATA = 3'h1;
  localparam logic [2:0] CR_CMD = 3'h2;
  localparam logic [2:0] CR_RDATA = 3'h3;
  localparam logic [2:0] CR_STATUS = 3'h4;
  localparam int B_T_SIZE = 8;
  localparam int B_T_DBG = 12;
  localparam int B_CMD_WR = 0;
  localparam int B_CMD_RD = 1;
endpackage

// [design/evr_if.sv]
// Interface joining the event router and its controller
`timescale 1ns/1ns
`default_nettype none
interface evr_if #(
  parameter int NUM_GEN = 74,
  parameter int NUM_USERS = 29
);
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [1:0] size;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic wprot;
  logic dbg_access;
  logic cpu_halted;
  logic [NUM_GEN-1:0] gen_evt;
  logic [NUM_USERS-1:0] user_ready;
  logic [NUM_USERS-1:0] user_evt;
  logic [11:0] gclk_req;
  logic irq;
  modport dev (
    input addr, wdata, size, wr, rd, wprot, dbg_access, cpu_halted,
    input gen_evt, user_ready,
    output rdata, user_evt, gclk_req, irq
  );
  modport host (
    output addr, wdata, size, wr, rd, wprot, dbg_access, cpu_halted,
    output gen_evt, user_ready,
    input rdata, user_evt, gclk_req, irq
  );
endinterface
`default_nettype wire

// [design/evr_router.sv]
// Event router: channels, user multiplexers and register file
// Overview of operation
// [RQ1] Each channel picks one generator; sharing allowed
// [RQ2] Software programs user mux before channel
// [RQ3] One multiplexer per user selects one channel
// [RQ4] User config: 16-bit write, 8-bit index readback
// [RQ5] Channel config: 32-bit write, 8-bit index readback
// [RQ6] No enable; always running after reset
// [RQ7] Soft reset clears registers, cancels events
// [RQ8] Three paths: async, sync, resync
// [RQ9] Async path passes generator without clocking
// [RQ10] Async: no interrupts, zero status, no edges
// [RQ11] Clocked paths detect rising, falling, both
// [RQ12] Sync only with shared clock, else async
// [RQ13] Resync path resamples generator into channel clock
// [RQ14] Clocked paths raise interrupts, update status
// [RQ15] Clock requested on demand unless always-request set
// [RQ16] Software command emits a channel event
// [RQ17] Keeps running in debug unless debug stop set
// [RQ18] Write protection except flags; debugger bypasses
// [RQ19] One interrupt request output
// [RQ20] Clocked paths need edge mode; no both for pulses
// [RQ21] Generator selection resets to zero, unconnected
// [RQ22] Twelve channels, any generator
// [RQ23] Soft reset bit clears itself
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module evr_router #(
  parameter int NUM_GEN = 74,
  parameter int NUM_USERS = 29
) (
  input wire logic sys_clk,
  input wire logic rst,
  evr_if.dev bus
);
  import evr_pkg::*;
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic gen_pick(input logic [NUM_GEN-1:0] g,
                                    input logic [GENERATOR_SELECT_W-1:0] sel);
    gen_pick = (sel != '0 && int'(sel) <= NUM_GEN) ? g[int'(sel) - 1] : 1'b0;
  endfunction
  function automatic logic edge_hit(input logic [1:0] mode,
                                    input logic now, input logic old);
    case (mode)
      EDGE_RISE: edge_hit = now & ~old;
      EDGE_FALL: edge_hit = ~now & old;
      EDGE_BOTH: edge_hit = now ^ old;
      default: edge_hit = 1'b0;
    endcase
  endfunction
  // ****************************************
  // Registers
  // ****************************************
  logic srst_reg, clk_req_all_reg, dbg_stop_reg;
  logic [CH_IDX_W-1:0] ch_idx_reg;
  logic [USR_IDX_W-1:0] usr_idx_reg;
  logic [CH_SEL_W-1:0] usr_sel_reg [NUM_USERS];
  logic [GENERATOR_SELECT_W-1:0] ch_gen_reg [NUM_CH];
  logic [1:0] ch_path_reg [NUM_CH];
  logic [1:0] ch_edge_reg [NUM_CH];
  logic [NUM_CH-1:0] en_ovr_reg, en_evd_reg, flag_ovr_reg, flag_evd_reg;
  logic [NUM_CH-1:0] busy_reg, pulse_reg, usr_rdy, ch_out, clocked;
  logic [NUM_CH-1:0] evt, sw_pulse, set_ovr;
  logic [31:0] rdata_reg, flag_clr;
  logic clr, wr_ok, halt_now;
  // Soft reset lasts exactly one cycle and then frees itself
  assign clr = rst | srst_reg; // [RQ7] [RQ23]
  // Interrupt flags stay writable; debugger writes ignore protection
  assign wr_ok = bus.wr & (~bus.wprot | bus.dbg_access); // [RQ18]
  assign halt_now = dbg_stop_reg & bus.cpu_halted; // [RQ17]
  assign flag_clr = (bus.wr && bus.addr == OFF_IRQ_FLAG_REG) ? // [RQ18]
                    bus.wdata : '0;
  // No enable bit exists: the fabric runs whenever clr is low [RQ6]
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      srst_reg <= 1'b0;
      clk_req_all_reg <= 1'b0;
      dbg_stop_reg <= 1'b0;
    end else if (wr_ok && bus.addr == OFF_CTRL) begin
      srst_reg <= bus.wdata[B_SRST]; // [RQ7]
      clk_req_all_reg <= bus.wdata[B_CLKREQ];
      dbg_stop_reg <= bus.wdata[B_DBGSTOP];
    end
  end
  // ****************************************
  // Channel configuration
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      ch_idx_reg <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        ch_gen_reg[i] <= '0; // [RQ21]
        ch_path_reg[i] <= PATH_SYNC;
        ch_edge_reg[i] <= EDGE_NONE;
      end
    end else if (wr_ok && bus.addr == OFF_CHANNEL) begin
      ch_idx_reg <= bus.wdata[B_CH_IDX +: CH_IDX_W]; // [RQ5]
      if (bus.size == SZ_WORD) begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (int'(bus.wdata[B_CH_IDX +: CH_IDX_W]) == i) begin
            ch_gen_reg[i] <= bus.wdata[B_GENERATOR_SELECT +: GENERATOR_SELECT_W]; // [RQ1]
            ch_path_reg[i] <= bus.wdata[B_PATH +: 2]; // [RQ8]
            ch_edge_reg[i] <= bus.wdata[B_EDGE +: 2];
          end
        end
      end
    end
  end
  // ****************************************
  // User multiplexer configuration
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      usr_idx_reg <= '0;
      for (int u = 0; u < NUM_USERS; u++) begin
        usr_sel_reg[u] <= '0;
      end
    end else if (wr_ok && bus.addr == OFF_USER) begin
      usr_idx_reg <= bus.wdata[B_USR_IDX +: USR_IDX_W]; // [RQ4]
      if (bus.size == SZ_HALF) begin
        for (int u = 0; u < NUM_USERS; u++) begin
          if (int'(bus.wdata[B_USR_IDX +: USR_IDX_W]) == u) begin
            usr_sel_reg[u] <= bus.wdata[B_USR_CH +: CH_SEL_W];
          end
        end
      end
    end
  end
  // ****************************************
  // Channel datapath
  // ****************************************
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic raw, sync1_reg, sync2_reg, prev_reg, sample;
    assign raw = gen_pick(bus.gen_evt, ch_gen_reg[g]); // [RQ1] [RQ22]
    assign clocked[g] = ch_path_reg[g] != PATH_ASYNC;
    assign sample = (ch_path_reg[g] == PATH_RESYNC) ? sync2_reg : raw;
    assign sw_pulse[g] = wr_ok && bus.addr == OFF_CHANNEL &&
                         bus.size == SZ_WORD && bus.wdata[B_SOFT_EVENT_BIT] &&
                         int'(bus.wdata[B_CH_IDX +: CH_IDX_W]) == g; // [RQ16]
    assign evt[g] = clocked[g] & ~halt_now &
                    (edge_hit(ch_edge_reg[g], sample, prev_reg) |
                     sw_pulse[g]); // [RQ11]
    assign ch_out[g] = clocked[g] ? pulse_reg[g] : raw; // [RQ8] [RQ9]
    assign set_ovr[g] = evt[g] & (busy_reg[g] | ~usr_rdy[g]);
    // Clocked channels want the clock while something moves through them, or always when clk_req_all_reg is set
    assign bus.gclk_req[g] = clocked[g] & (clk_req_all_reg |
                             busy_reg[g] | pulse_reg[g] |
                             (raw ^ prev_reg)); // [RQ15]
    always_ff @(posedge sys_clk) begin
      if (clr) begin
        sync1_reg <= 1'b0;
        sync2_reg <= 1'b0;
        prev_reg <= 1'b0;
      end else begin
        sync1_reg <= raw; // [RQ13]
        sync2_reg <= sync1_reg;
        if (!halt_now) begin
          prev_reg <= sample;
        end
      end
    end
    always_ff @(posedge sys_clk) begin
      if (clr) begin
        pulse_reg[g] <= 1'b0;
        busy_reg[g] <= 1'b0;
      end else begin
        pulse_reg[g] <= evt[g];
        busy_reg[g] <= evt[g] | (busy_reg[g] & ~usr_rdy[g]);
      end
    end
  end
  // ****************************************
  // User side
  // ****************************************
  // Selection 0 means no channel; n selects channel n-1
  always_comb begin
    usr_rdy = '1;
    bus.user_evt = '0;
    for (int u = 0; u < NUM_USERS; u++) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (int'(usr_sel_reg[u]) == c + 1) begin
          bus.user_evt[u] = ch_out[c]; // [RQ3]
          usr_rdy[c] = usr_rdy[c] & bus.user_ready[u];
        end
      end
    end
  end
  // ****************************************
  // Interrupt enables and flags
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      en_ovr_reg <= '0;
      en_evd_reg <= '0;
    end else if (wr_ok && bus.addr == OFF_INTEN_SET) begin
      en_ovr_reg <= en_ovr_reg | bus.wdata[0 +: NUM_CH];
      en_evd_reg <= en_evd_reg | bus.wdata[B_HI +: NUM_CH];
    end else if (wr_ok && bus.addr == OFF_INTEN_CLR) begin
      en_ovr_reg <= en_ovr_reg & ~bus.wdata[0 +: NUM_CH];
      en_evd_reg <= en_evd_reg & ~bus.wdata[B_HI +: NUM_CH];
    end
  end
  // Write-one-to-clear; a new event beats the clear
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      flag_ovr_reg <= '0;
      flag_evd_reg <= '0;
    end else begin
      flag_ovr_reg <= (flag_ovr_reg & ~flag_clr[0 +: NUM_CH]) | set_ovr;
      flag_evd_reg <= (flag_evd_reg & ~flag_clr[B_HI +: NUM_CH]) |
                      evt; // [RQ14]
    end
  end
  // Async channels never set flags since evt is masked [RQ10]
  assign bus.irq = |((flag_ovr_reg & en_ovr_reg) |
                     (flag_evd_reg & en_evd_reg)); // [RQ19]
  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      rdata_reg <= '0;
    end else if (bus.rd) begin
      rdata_reg <= '0;
      case (bus.addr)
        OFF_CTRL: begin
          rdata_reg[B_SRST] <= srst_reg;
          rdata_reg[B_CLKREQ] <= clk_req_all_reg;
          rdata_reg[B_DBGSTOP] <= dbg_stop_reg;
        end
        OFF_CHANNEL: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (int'(ch_idx_reg) == i) begin // [RQ5]
              rdata_reg[B_CH_IDX +: CH_IDX_W] <= ch_idx_reg;
              rdata_reg[B_GENERATOR_SELECT +: GENERATOR_SELECT_W] <= ch_gen_reg[i];
              rdata_reg[B_PATH +: 2] <= ch_path_reg[i];
              rdata_reg[B_EDGE +: 2] <= ch_edge_reg[i];
            end
          end
        end
        OFF_USER: begin
          rdata_reg[B_USR_IDX +: USR_IDX_W] <= usr_idx_reg;
          for (int u = 0; u < NUM_USERS; u++) begin
            if (int'(usr_idx_reg) == u) begin // [RQ4]
              rdata_reg[B_USR_CH +: CH_SEL_W] <= usr_sel_reg[u];
            end
          end
        end
        OFF_CHSTATE: begin
          rdata_reg[0 +: NUM_CH] <= usr_rdy & clocked; // [RQ10] [RQ14]
          rdata_reg[B_HI +: NUM_CH] <= busy_reg & clocked;
        end
        OFF_INTEN_CLR, OFF_INTEN_SET: begin
          rdata_reg[0 +: NUM_CH] <= en_ovr_reg;
          rdata_reg[B_HI +: NUM_CH] <= en_evd_reg;
        end
        OFF_IRQ_FLAG_REG: begin
          rdata_reg[0 +: NUM_CH] <= flag_ovr_reg;
          rdata_reg[B_HI +: NUM_CH] <= flag_evd_reg;
        end
        default: rdata_reg <= '0;
      endcase
    end
  end
  assign bus.rdata = rdata_reg;
endmodule
`default_nettype wire

// [design/evr_ctl.sv]
// Controller end: turns software orders into router bus accesses
`timescale 1ns/1ns
`default_nettype none
module evr_ctl #(
  parameter int NUM_GEN = 74,
  parameter int NUM_USERS = 29
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  input wire logic [NUM_GEN-1:0] gen_in,
  input wire logic [NUM_USERS-1:0] user_ready_in,
  input wire logic cpu_halted_in,
  input wire logic wprot_in,
  output logic [NUM_USERS-1:0] user_evt_out,
  output logic [evr_pkg::NUM_CH-1:0] gclk_req_out,
  output logic irq_out,
  evr_if.host bus
);
  import evr_pkg::*;

  typedef enum {ST_IDLE, ST_WRITE, ST_READ, ST_CAPT} evr_st_t;
  evr_st_t state_reg;
  logic [7:0] taddr_reg;
  logic [1:0] tsize_reg;
  logic tdbg_reg;
  logic [31:0] twdata_reg, trdata_reg, sw_rdata_reg;
  logic done_reg;
  logic go_wr, go_rd;

  // Orders arriving while busy are dropped; software polls status first
  assign go_wr = sw_wr && sw_addr == CR_CMD && state_reg == ST_IDLE;
  assign go_rd = go_wr && sw_wdata[B_CMD_RD] && !sw_wdata[B_CMD_WR];

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      taddr_reg <= '0;
      tsize_reg <= SZ_BYTE;
      tdbg_reg <= 1'b0;
      twdata_reg <= '0;
    end else if (sw_wr && sw_addr == CR_TARGET) begin
      taddr_reg <= sw_wdata[7:0];
      tsize_reg <= sw_wdata[B_T_SIZE +: 2];
      tdbg_reg <= sw_wdata[B_T_DBG];
    end else if (sw_wr && sw_addr == CR_WDATA) begin
      twdata_reg <= sw_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sw_rdata_reg <= '0;
    end else if (sw_rd) begin
      case (sw_addr)
        CR_TARGET: sw_rdata_reg <= {19'h0, tdbg_reg, 2'h0, tsize_reg,
                                    taddr_reg};
        CR_WDATA: sw_rdata_reg <= twdata_reg;
        CR_RDATA: sw_rdata_reg <= trdata_reg;
        CR_STATUS: sw_rdata_reg <= {30'h0, state_reg != ST_IDLE, done_reg};
        default: sw_rdata_reg <= '0;
      endcase
    end
  end
  assign sw_rdata = sw_rdata_reg;

  // ****************************************
  // Bus sequencer
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      done_reg <= 1'b0;
      trdata_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go_rd) begin
            state_reg <= ST_READ;
            done_reg <= 1'b0;
          end else if (go_wr && sw_wdata[B_CMD_WR]) begin
            state_reg <= ST_WRITE;
            done_reg <= 1'b0;
          end
        end
        ST_WRITE: begin
          state_reg <= ST_IDLE;
          done_reg <= 1'b1;
        end
        ST_READ: state_reg <= ST_CAPT;
        ST_CAPT: begin
          trdata_reg <= bus.rdata;
          state_reg <= ST_IDLE;
          done_reg <= 1'b1;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Orders follow the user-mux-first sequence chosen by software [RQ2]
  assign bus.wr = state_reg == ST_WRITE;
  assign bus.rd = state_reg == ST_READ;
  assign bus.addr = taddr_reg;
  assign bus.wdata = twdata_reg; // [RQ4] [RQ5]
  assign bus.size = tsize_reg;
  assign bus.dbg_access = tdbg_reg;
  assign bus.wprot = wprot_in;
  assign bus.cpu_halted = cpu_halted_in;
  // Path and edge choices are left to software [RQ12] [RQ20]
  assign bus.gen_evt = gen_in;
  assign bus.user_ready = user_ready_in;
  assign user_evt_out = bus.user_evt;
  assign gclk_req_out = bus.gclk_req;
  assign irq_out = bus.irq;
endmodule
`default_nettype wire

// [bench/evr_asserts.sv]
// Wire checks between the event router and its controller
`timescale 1ns/1ns
`default_nettype none
module evr_asserts #(
  parameter int NUM_USERS = 29
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [1:0] size,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic wprot,
  input wire logic dbg_access,
  input wire logic [NUM_USERS-1:0] user_evt,
  input wire logic [11:0] gclk_req,
  input wire logic irq
);
  import evr_pkg::*;
  logic ctrl_wr_q;
  logic usr_seen;
  logic cfg_seen;
  logic ien_seen;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ****************************************
  // Helper state
  // ****************************************
  // A soft reset clears read data one edge after the control write
  always_ff @(posedge sys_clk) begin
    ctrl_wr_q <= !rst && wr && addr == OFF_CTRL;
  end
  // Conservative: once armed, a flag stays set even across a soft reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      usr_seen <= 1'b0;
      cfg_seen <= 1'b0;
      ien_seen <= 1'b0;
    end else begin
      usr_seen <= usr_seen || (wr && addr == OFF_USER && size == SZ_HALF);
      cfg_seen <= cfg_seen || (wr && (addr == OFF_CHANNEL || addr == OFF_CTRL));
      ien_seen <= ien_seen || (wr && addr == OFF_INTEN_SET);
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  reset_quiet_a: assert property (
    $fell(rst) |-> !wr && !rd && !irq && user_evt == '0 &&
      gclk_req == 12'h000 && rdata == 32'h0000_0000)
    else $error("outputs not quiet after reset");
  strobe_excl_a: assert property (!(wr && rd))
    else $error("read and write strobes together");
  strobe_pulse_a: assert property ((wr || rd) |=> !wr && !rd)
    else $error("bus strobe longer than one cycle");
  unmapped_zero_a: assert property (
    rd && addr > OFF_IRQ_FLAG_REG |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd && !ctrl_wr_q |=> $stable(rdata))
    else $error("read data changed without a read");
  srst_clear_a: assert property (
    wr && addr == OFF_CTRL && wdata[B_SRST] && (!wprot || dbg_access)
      |-> ##2 (!irq && gclk_req == 12'h000 && user_evt == '0))
    else $error("soft reset left outputs active");
  irq_gate_a: assert property (!ien_seen |-> !irq)
    else $error("interrupt with nothing enabled");
  evt_gate_a: assert property (!usr_seen |-> user_evt == '0)
    else $error("user event with no multiplexer set");
  gclk_gate_a: assert property (!cfg_seen |-> gclk_req == 12'h000)
    else $error("clock request with idle channels");
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Bench joining controller and router, driven through the software port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import evr_pkg::*;
  localparam int NG = 8;
  localparam int NU = 4;
  localparam logic [31:0] CFG_M = 32'h0FFF_0000;
  logic sys_clk;
  logic rst;
  logic [2:0] sw_addr;
  logic [31:0] sw_wdata;
  logic sw_wr;
  logic sw_rd;
  logic [31:0] sw_rdata;
  logic [NG-1:0] gen_in;
  logic [NU-1:0] user_ready_in;
  logic cpu_halted_in;
  logic wprot_in;
  logic [NU-1:0] user_evt_out;
  logic [NUM_CH-1:0] gclk_req_out;
  logic irq_out;
  logic [31:0] rd_val;
  int num_errors;
  int checks_done;
  int ev0, ev1;
  evr_if #(.NUM_GEN(NG), .NUM_USERS(NU)) evr_if_i ();
  evr_router #(.NUM_GEN(NG), .NUM_USERS(NU)) evr_router_i (
    .sys_clk(sys_clk), .rst(rst), .bus(evr_if_i.dev));
  evr_ctl #(.NUM_GEN(NG), .NUM_USERS(NU)) evr_ctl_i (
    .sys_clk(sys_clk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .gen_in(gen_in),
    .user_ready_in(user_ready_in), .cpu_halted_in(cpu_halted_in),
    .wprot_in(wprot_in), .user_evt_out(user_evt_out),
    .gclk_req_out(gclk_req_out), .irq_out(irq_out), .bus(evr_if_i.host));
  evr_asserts #(.NUM_USERS(NU)) evr_asserts_i (
    .sys_clk(sys_clk), .rst(rst), .addr(evr_if_i.addr),
    .wdata(evr_if_i.wdata), .size(evr_if_i.size), .wr(evr_if_i.wr),
    .rd(evr_if_i.rd), .rdata(evr_if_i.rdata), .wprot(evr_if_i.wprot),
    .dbg_access(evr_if_i.dbg_access), .user_evt(evr_if_i.user_evt),
    .gclk_req(evr_if_i.gclk_req), .irq(evr_if_i.irq));
  always #5 sys_clk = ~sys_clk;
  // Counts cycles with the pulse high, so a stuck output shows as extra
  always @(posedge sys_clk) begin
    ev0 += (user_evt_out[0] === 1'b1);
    ev1 += (user_evt_out[1] === 1'b1);
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sw_w(input logic [2:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_r(input logic [2:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic bus_op(input logic [7:0] a, input logic [1:0] sz,
                        input logic dbg, input logic w, input logic [31:0] d);
    logic [31:0] s;
    int n;
    s = 32'h0;
    n = 0;
    sw_w(CR_TARGET, {19'h0, dbg, 2'h0, sz, a});
    sw_w(CR_WDATA, d);
    sw_w(CR_CMD, {30'h0, !w, w});
    while (s[0] !== 1'b1 && n < 20) begin
      sw_r(CR_STATUS, s);
      n++;
    end
    if (s[0] !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t: controller never finished", $time);
      wrap_up();
    end
    if (!w) sw_r(CR_RDATA, rd_val);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [1:0] sz,
                      input logic [31:0] d);
    bus_op(a, sz, 1'b0, 1'b1, d);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [1:0] sz);
    bus_op(a, sz, 1'b0, 1'b0, 32'h0);
  endtask
  task automatic rd_chan(input logic [3:0] ch);
    wreg(OFF_CHANNEL, SZ_BYTE, {28'h0, ch});
    rreg(OFF_CHANNEL, SZ_WORD);
  endtask
  task automatic rd_user(input logic [4:0] u);
    wreg(OFF_USER, SZ_BYTE, {27'h0, u});
    rreg(OFF_USER, SZ_HALF);
  endtask
  function automatic logic [31:0] cfg(input logic [3:0] ch,
    input logic [6:0] gen, input logic [1:0] path, input logic [1:0] edg,
    input logic sw);
    return {4'h0, edg, path, 1'b0, gen, 7'h00, sw, 4'h0, ch};
  endfunction
  task automatic pulse_gen;
    @(posedge sys_clk);
    gen_in[0] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    gen_in[0] <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_zero;
    rreg(OFF_CTRL, SZ_BYTE);
    chk(rd_val & 32'h0000_0011, 32'h0);
    rd_chan(4'h1);
    chk(rd_val & CFG_M, 32'h0);
    rd_user(5'h1);
    chk(rd_val & 32'h0000_1F00, 32'h0);
    rreg(OFF_IRQ_FLAG_REG, SZ_WORD);
    chk(rd_val, 32'h0);
    $display("reset state test done");
  endtask
  task automatic t_route;
    int x;
    wreg(OFF_USER, SZ_HALF, 32'h0000_0100);
    wreg(OFF_USER, SZ_HALF, 32'h0000_0201);
    rd_user(5'h1);
    chk(rd_val & 32'h0000_1F1F, 32'h0000_0201);
    for (int p = 0; p < 2; p++) begin
      cpu_halted_in <= p[0];
      for (int e = 0; e < 4; e++) begin
        wreg(OFF_CHANNEL, SZ_WORD, cfg(4'h0, 7'h01, p[1:0], e[1:0], 1'b0));
        wreg(OFF_CHANNEL, SZ_WORD, cfg(4'h1, 7'h01, p[1:0], e[1:0], 1'b0));
        ev0 = 0;
        ev1 = 0;
        pulse_gen();
        x = (e == 3) ? 2 : (e == 0) ? 0 : 1;
        chk(32'(ev0), 32'(x));
        chk(32'(ev1), 32'(x));
      end
    end
    // Debug stop with the processor halted freezes clocked channels
    wreg(OFF_CTRL, SZ_BYTE, 32'h0000_0040);
    ev0 = 0;
    pulse_gen();
    chk(32'(ev0), 32'h0);
    cpu_halted_in <= 1'b0;
    $display("routing test done");
  endtask
  task automatic t_async;
    wreg(OFF_CTRL, SZ_BYTE, 32'h0000_0010);
    wreg(OFF_CHANNEL, SZ_WORD, cfg(4'h0, 7'h01, PATH_ASYNC, EDGE_NONE, 1'b0));
    chk({31'h0, gclk_req_out[0]}, 32'h0);
    chk({31'h0, gclk_req_out[1]}, 32'h1);
    rd_chan(4'h0);
    chk(rd_val & CFG_M, cfg(4'h0, 7'h01, PATH_ASYNC, 2'h0, 1'b0) & CFG_M);
    rd_chan(4'h1);
    chk(rd_val & CFG_M, cfg(4'h1, 7'h01, PATH_RESYNC, 2'h3, 1'b0) & CFG_M);
    wreg(OFF_IRQ_FLAG_REG, SZ_WORD, 32'hFFFF_FFFF);
    @(posedge sys_clk);
    gen_in[0] <= 1'b1;
    #1 chk({31'h0, user_evt_out[0]}, 32'h1);
    repeat (4) @(posedge sys_clk);
    rreg(OFF_CHSTATE, SZ_WORD);
    chk(rd_val & 32'h0001_0000, 32'h0);
    rreg(OFF_IRQ_FLAG_REG, SZ_WORD);
    chk(rd_val & 32'h0001_0001, 32'h0);
    @(posedge sys_clk);
    gen_in[0] <= 1'b0;
    #1 chk({31'h0, user_evt_out[0]}, 32'h0);
    wreg(OFF_CTRL, SZ_BYTE, 32'h0);
    chk({31'h0, gclk_req_out[1]}, 32'h0);
    $display("async path test done");
  endtask
  task automatic t_irq;
    wreg(OFF_CHANNEL, SZ_WORD, cfg(4'h0, 7'h01, PATH_SYNC, EDGE_RISE, 1'b0));
    wreg(OFF_IRQ_FLAG_REG, SZ_WORD, 32'hFFFF_FFFF);
    wreg(OFF_INTEN_SET, SZ_WORD, 32'h0001_0000);
    chk({31'h0, irq_out}, 32'h0);
    @(posedge sys_clk);
    gen_in[0] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({31'h0, irq_out}, 32'h1);
    wprot_in <= 1'b1;
    wreg(OFF_IRQ_FLAG_REG, SZ_WORD, 32'h0001_0000);
    chk({31'h0, irq_out}, 32'h0);
    wreg(OFF_INTEN_CLR, SZ_WORD, 32'h0001_0000);
    rreg(OFF_INTEN_SET, SZ_WORD);
    chk(rd_val & 32'h0001_0000, 32'h0001_0000);
    bus_op(OFF_INTEN_CLR, SZ_WORD, 1'b1, 1'b1, 32'h0001_0000);
    rreg(OFF_INTEN_SET, SZ_WORD);
    chk(rd_val & 32'h0001_0000, 32'h0);
    @(posedge sys_clk);
    wprot_in <= 1'b0;
    gen_in[0] <= 1'b0;
    $display("interrupt test done");
  endtask
  task automatic t_soft;
    wreg(OFF_CTRL, SZ_BYTE, 32'h0000_0010);
    ev0 = 0;
    wreg(OFF_CHANNEL, SZ_WORD, cfg(4'h0, 7'h00, PATH_SYNC, EDGE_RISE, 1'b1));
    repeat (4) @(posedge sys_clk);
    chk(32'(ev0), 32'h1);
    rreg(8'h40, SZ_WORD);
    chk(rd_val, 32'h0);
    wreg(OFF_CTRL, SZ_BYTE, 32'h0000_0001);
    chk({20'h0, gclk_req_out}, 32'h0);
    t_zero();
    $display("soft reset test done");
  endtask
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    sw_addr = 3'h0;
    sw_wdata = 32'h0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    gen_in = '0;
    user_ready_in = '1;
    cpu_halted_in = 1'b0;
    wprot_in = 1'b0;
    num_errors = 0;
    checks_done = 0;
    ev0 = 0;
    ev1 = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_zero();
    t_route();
    t_async();
    t_irq();
    t_soft();
    wrap_up();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    $display("ERROR %0t: run took too long", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
